// *** mmc_pkg.sv ***
package mmc_pkg;

  // ==========================================================
  // Local address map
  // ==========================================================
  localparam logic [27:0] A08_BASE = 28'h8000000;
  localparam logic [15:0] A08_PAGE = 16'h8000;
  localparam int A08_D32_BIT = 11;
  localparam int A08_SLOT_LSB = 9;
  localparam int A08_REG_BIT = 8;
  localparam logic [11:0] SLOT_STRIDE = 12'h200;
  localparam logic [11:0] IRQ_REG_OFS = 12'h100;
  localparam logic [27:0] SLOT0_IRQ_CTRL_D16 = 28'h8000100;
  localparam logic [27:0] SLOT1_IRQ_CTRL_D16 = 28'h8000300;
  localparam logic [27:0] SLOT2_IRQ_CTRL_D16 = 28'h8000500;
  localparam logic [27:0] SLOT3_IRQ_CTRL_D16 = 28'h8000700;
  localparam logic [27:0] SLOT0_IRQ_CTRL_D32 = 28'h8000900;
  localparam logic [27:0] SLOT1_IRQ_CTRL_D32 = 28'h8000b00;
  localparam logic [27:0] SLOT2_IRQ_CTRL_D32 = 28'h8000d00;
  localparam logic [27:0] SLOT3_IRQ_CTRL_D32 = 28'h8000f00;
  localparam logic [1:0] A24_D16_SEL = 2'h0;
  localparam logic [1:0] A24_D32_SEL = 2'h1;
  localparam int A24_SEL_LSB = 26;
  localparam int A24_SLOT_LSB = 24;

  // ==========================================================
  // Interrupt control register fields
  // ==========================================================
  localparam int PEND_BIT = 0;
  localparam int GATE_BIT = 1;
  localparam int TOF_BIT = 2;
  localparam int AEF_BIT = 3;
  localparam logic [3:0] GATE_RST = 4'h0;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 50;
  localparam int TIMEOUT_NS = 16000;
  localparam int TIMEOUT_CYC = (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 9;

  // ==========================================================
  // Bridge factory image, word index = byte offset / 4
  // ==========================================================
  localparam int EE_WORDS = 25;
  localparam logic [31:0] EE_DEVICE_ID = 32'h1234abcd;   // Arbitrary value
  localparam logic [31:0] EE_SUBSYS_ID = 32'h5678abcd;   // Arbitrary value
  localparam logic [31:0] EE_CLASS = 32'h08010001;
  localparam logic [31:0] EE_CONF = 32'h00000100;
  localparam logic [31:0] EE_SPACE0_RANGE = 32'h0ffff800;
  localparam logic [31:0] EE_SPACE1_RANGE = 32'h0ffff801;
  localparam logic [31:0] EE_SPACE2_RANGE = 32'h0ffff800;
  localparam logic [31:0] EE_SPACE0_REMAP = 32'h08000001;
  localparam logic [31:0] EE_SPACE1_REMAP = 32'h08000001;
  localparam logic [31:0] EE_SPACE2_REMAP = 32'h08000801;
  localparam logic [31:0] EE_SPACE0_DESC = 32'h00400002;
  localparam logic [31:0] EE_SPACE1_DESC = 32'h00400002;
  localparam logic [31:0] EE_SPACE2_DESC = 32'h00800002;
  localparam logic [31:0] EE_CNTRL = 32'h00220000;

  typedef enum logic [2:0] {
    MMC_IDLE,
    MMC_ADDR,
    MMC_STRB,
    MMC_DONE
  } mmc_state_t;

  typedef struct packed {
    logic hit;
    logic regs;
    logic d32;
    logic a24;
    logic [1:0] slot;
  } mmc_dec_t;

endpackage : mmc_pkg

// *** mmc_tmr_if.sv ***
interface mmc_tmr_if;
  logic run;
  logic expired;
  modport owner (output run, input expired);
  modport timer (input run, output expired);
endinterface : mmc_tmr_if

// *** mmc_bus_timer.sv ***
module mmc_bus_timer (
  input wire logic core_clk_i,  // Core clock
  input wire logic rst_n_i,     // Sync reset
  mmc_tmr_if.timer tmr          // Timer control
);

  typedef struct packed {
    logic [mmc_pkg::TMR_W-1:0] cnt;
    logic expired;
  } mmc_tmr_t;

  mmc_tmr_t s_r;
  mmc_tmr_t s_nxt;

  // ==========================================================
  // Select-to-acknowledge watchdog
  // ==========================================================
  always_comb begin
    s_nxt = s_r;
    s_nxt.expired = 1'b0;
    if (!tmr.run) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt == mmc_pkg::TMR_W'(mmc_pkg::TIMEOUT_CYC - 1)) begin
      s_nxt.expired = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tmr.expired = s_r.expired;

endmodule : mmc_bus_timer

// *** mmc_carrier.sv ***
// Functional notes
// - One local bus setup for all slots: 16 or 32 bits, muxed or not.
// - Space 0 serves A08/D16 memory mapped module and register accesses, little endian.
// - Space 1 serves A08/D16 I/O mapped module and register accesses, little endian.
// - Space 2 serves A08/D32 memory mapped module and register accesses, little endian.
// - Local data bit n connects straight to module data bit n.
// - Accesses end through the bridge ready input, not fixed wait states.
// - This logic makes all module strobe timing; bridge only requests.
// - A08/D16 slot n window is 256 bytes at 0x0800_0000 plus n*0x200.
// - Interrupt control register sits 0x100 above each A08 window.
// - A08/D32 slot n window is 256 bytes at 0x0800_0800 plus n*0x200.
// - A24/D16 slot n owns 16 MB at n*0x0100_0000.
// - A24/D32 slot 0 owns 0x0400_0000 to 0x04ff_ffff.
// - Module requests go to irq input a; timeout and lane error to b.
// - Each slot has its own interrupt control register.
// - Bridge loads factory image before local accesses are served.
// - Image gives space 0 range 0ffff800 and remap 08000001.
// - Image gives space 1 range 0ffff801 (I/O) and remap 08000001.
// - Image gives space 2 range 0ffff800 and remap 08000801.
// - Descriptors 00400002 for spaces 0,1, 00800002 for 2; rest zero.
// - No acknowledge within 16 us: self-acknowledge, set timeout flag, interrupt.
// - Split-word byte request in D32 sets lane error flag; write 0 clears.
// - Pending mirrors module request, gate enables it, timeout cleared by 0.
module mmc_carrier (
  input wire logic core_clk_i,              // Core clock
  input wire logic rst_n_i,                 // Sync reset
  input wire logic lb_bus32_i,              // Local bus is 32 bits
  input wire logic lb_mux_i,                // Address rides on data lines
  input wire logic lb_load_done_i,          // Bridge finished image load
  input wire logic lb_ads_n_i,              // Address strobe
  input wire logic [27:0] lb_addr_i,        // Local address
  input wire logic lb_wr_i,                 // Write when high
  input wire logic [3:0] lb_be_n_i,         // Byte enables
  input wire logic [31:0] lb_data_i,        // Local data in
  output logic [31:0] lb_data_o,            // Local data out
  output logic lb_data_oe_o,                // Local data drive
  output logic lb_ready_n_o,                // Transfer end
  output logic local_irq_input_a_o,         // Module interrupts
  output logic local_irq_input_b_o,         // Timeout and lane error
  input wire logic [4:0] ee_word_i,         // Image word index
  output logic [31:0] ee_data_o,            // Image word
  output logic [3:0] slot_cs_n_o,           // Slot select
  output logic slot_as_n_o,                 // Address phase strobe
  output logic [3:0] slot_ds_n_o,           // Byte strobes
  output logic slot_wr_n_o,                 // Write strobe
  output logic [7:1] slot_addr_o,           // Module address lines
  output logic [31:0] slot_data_o,          // Module data out
  output logic slot_data_oe_o,              // Module data drive
  input wire logic [31:0] slot_data_i,      // Module data in
  input wire logic [3:0] slot_dtack_n_i,    // Module acknowledge
  input wire logic [3:0] slot_irq_n_i       // Module interrupt request
);

  typedef struct packed {
    mmc_pkg::mmc_state_t st;
    logic [27:0] addr;
    logic wr;
    logic [3:0] be_n;
    logic [31:0] wdat;
    mmc_pkg::mmc_dec_t dec;
    logic [3:0] gate;
    logic [3:0] tof;
    logic [3:0] aef;
    logic [3:0] pend;
    logic rdy_n;
    logic [31:0] rdat;
    logic dat_oe;
    logic [3:0] cs_n;
    logic as_n;
    logic [3:0] ds_n;
    logic wr_n;
    logic [7:1] maddr;
    logic [31:0] mdat;
    logic moe;
    logic irq_a;
    logic irq_b;
    logic [31:0] ee;
  } mmc_state_s_t;

  mmc_state_s_t s_r;
  mmc_state_s_t s_nxt;
  mmc_tmr_if tmr ();

  // ==========================================================
  // Address decode
  // ==========================================================
  function automatic mmc_pkg::mmc_dec_t decode(input logic [27:0] a);
    mmc_pkg::mmc_dec_t d;
    d = '0;
    if (a[27:12] == mmc_pkg::A08_PAGE) begin
      d.hit = 1'b1;
      d.d32 = a[mmc_pkg::A08_D32_BIT];
      d.slot = a[mmc_pkg::A08_SLOT_LSB +: 2];
      d.regs = a[mmc_pkg::A08_REG_BIT];
    end else if (a[mmc_pkg::A24_SEL_LSB +: 2] == mmc_pkg::A24_D16_SEL) begin
      d.hit = 1'b1;
      d.a24 = 1'b1;
      d.slot = a[mmc_pkg::A24_SLOT_LSB +: 2];
    end else if (a[mmc_pkg::A24_SEL_LSB +: 2] == mmc_pkg::A24_D32_SEL) begin
      d.hit = 1'b1;
      d.a24 = 1'b1;
      d.d32 = 1'b1;
      d.slot = a[mmc_pkg::A24_SLOT_LSB +: 2];
    end
    return d;
  endfunction : decode

  // Bytes requested in both halves of a double word, but not all four
  function automatic logic lane_split(input logic [3:0] be_n);
    return (~&be_n[1:0]) && (~&be_n[3:2]) && (|be_n);
  endfunction : lane_split

  function automatic logic [31:0] ee_word(input logic [4:0] w);
    logic [31:0] v;
    v = '0;
    case (w)
      5'h00: v = mmc_pkg::EE_DEVICE_ID;
      5'h01: v = mmc_pkg::EE_CLASS;
      5'h02: v = mmc_pkg::EE_SUBSYS_ID;
      5'h03: v = mmc_pkg::EE_CONF;
      5'h04: v = mmc_pkg::EE_SPACE0_RANGE;
      5'h05: v = mmc_pkg::EE_SPACE1_RANGE;
      5'h06: v = mmc_pkg::EE_SPACE2_RANGE;
      5'h09: v = mmc_pkg::EE_SPACE0_REMAP;
      5'h0a: v = mmc_pkg::EE_SPACE1_REMAP;
      5'h0b: v = mmc_pkg::EE_SPACE2_REMAP;
      5'h0e: v = mmc_pkg::EE_SPACE0_DESC;
      5'h0f: v = mmc_pkg::EE_SPACE1_DESC;
      5'h10: v = mmc_pkg::EE_SPACE2_DESC;
      5'h18: v = mmc_pkg::EE_CNTRL;
      default: v = '0;
    endcase
    return v;
  endfunction : ee_word

  // ==========================================================
  // Bus timer
  // ==========================================================
  mmc_bus_timer u_timer (
    .core_clk_i (core_clk_i),
    .rst_n_i (rst_n_i),
    .tmr (tmr.timer)
  );

  assign tmr.run = (s_r.st == mmc_pkg::MMC_STRB);

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    logic [27:0] a;
    mmc_pkg::mmc_dec_t d;
    logic [3:0] sel;
    logic [3:0] tset;
    logic [3:0] aset;
    logic [3:0] wclr_t;
    logic [3:0] wclr_a;
    a = lb_mux_i ? lb_data_i[27:0] : lb_addr_i;
    d = decode(a);
    sel = 4'h1 << s_r.dec.slot;
    tset = '0;
    aset = '0;
    wclr_t = '0;
    wclr_a = '0;
    s_nxt = s_r;
    s_nxt.rdy_n = 1'b1;
    s_nxt.dat_oe = 1'b0;
    s_nxt.pend = ~slot_irq_n_i;
    s_nxt.ee = ee_word(ee_word_i);
    case (s_r.st)
      mmc_pkg::MMC_IDLE: begin
        if (!lb_ads_n_i && lb_load_done_i) begin
          s_nxt.addr = a;
          s_nxt.wr = lb_wr_i;
          s_nxt.be_n = lb_be_n_i;
          s_nxt.wdat = lb_data_i;
          s_nxt.dec = d;
          s_nxt.st = mmc_pkg::MMC_DONE;
          s_nxt.rdat = '0;
          if (d.hit && d.regs) begin
            s_nxt.rdat = {28'h0, s_r.aef[d.slot], s_r.tof[d.slot],
                          s_r.gate[d.slot], s_r.pend[d.slot]};
            if (lb_wr_i && !lb_be_n_i[0]) begin
              s_nxt.gate[d.slot] = lb_data_i[mmc_pkg::GATE_BIT];
              wclr_t[d.slot] = ~lb_data_i[mmc_pkg::TOF_BIT];
              wclr_a[d.slot] = ~lb_data_i[mmc_pkg::AEF_BIT];
            end
          end else if (d.hit && d.d32 && lane_split(lb_be_n_i)) begin
            aset[d.slot] = 1'b1;
          end else if (d.hit) begin
            s_nxt.maddr = a[7:1];
            if (d.a24) begin
              s_nxt.st = mmc_pkg::MMC_ADDR;
              s_nxt.cs_n = ~(4'h1 << d.slot);
              s_nxt.as_n = 1'b0;
              s_nxt.mdat = {16'h0, a[23:8]};
              s_nxt.moe = 1'b1;
            end else begin
              s_nxt.st = mmc_pkg::MMC_STRB;
              s_nxt.cs_n = ~(4'h1 << d.slot);
              s_nxt.wr_n = ~lb_wr_i;
              s_nxt.ds_n = d.d32 ? lb_be_n_i : {2'h3, lb_be_n_i[1:0]};
              s_nxt.mdat = lb_data_i;
              s_nxt.moe = lb_wr_i;
            end
          end
        end
      end
      mmc_pkg::MMC_ADDR: begin
        s_nxt.as_n = 1'b1;
        s_nxt.st = mmc_pkg::MMC_STRB;
        s_nxt.wr_n = ~s_r.wr;
        s_nxt.ds_n = s_r.dec.d32 ? s_r.be_n : {2'h3, s_r.be_n[1:0]};
        s_nxt.mdat = s_r.wdat;
        s_nxt.moe = s_r.wr;
      end
      mmc_pkg::MMC_STRB: begin
        if (!slot_dtack_n_i[s_r.dec.slot] || tmr.expired) begin
          if (slot_dtack_n_i[s_r.dec.slot]) begin
            tset = sel;
          end
          s_nxt.rdat = slot_data_i;
          if (!s_r.dec.d32 || !lb_bus32_i) begin
            s_nxt.rdat[31:16] = 16'h0;
          end
          s_nxt.cs_n = 4'hf;
          s_nxt.ds_n = 4'hf;
          s_nxt.wr_n = 1'b1;
          s_nxt.moe = 1'b0;
          s_nxt.st = mmc_pkg::MMC_DONE;
        end
      end
      mmc_pkg::MMC_DONE: begin
        s_nxt.rdy_n = 1'b0;
        s_nxt.dat_oe = ~s_r.wr;
        s_nxt.st = mmc_pkg::MMC_IDLE;
      end
      default: begin
        s_nxt.st = mmc_pkg::MMC_IDLE;
      end
    endcase
    // Set wins over a same-cycle clear
    s_nxt.tof = (s_r.tof & ~wclr_t) | tset;
    s_nxt.aef = (s_r.aef & ~wclr_a) | aset;
    s_nxt.irq_a = |(s_r.pend & s_r.gate);
    s_nxt.irq_b = |(s_r.tof | s_r.aef);
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
      s_r.st <= mmc_pkg::MMC_IDLE;
      s_r.gate <= mmc_pkg::GATE_RST;
      s_r.rdy_n <= 1'b1;
      s_r.cs_n <= 4'hf;
      s_r.as_n <= 1'b1;
      s_r.ds_n <= 4'hf;
      s_r.wr_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign lb_data_o = s_r.rdat;
  assign lb_data_oe_o = s_r.dat_oe;
  assign lb_ready_n_o = s_r.rdy_n;
  assign local_irq_input_a_o = s_r.irq_a;
  assign local_irq_input_b_o = s_r.irq_b;
  assign ee_data_o = s_r.ee;
  assign slot_cs_n_o = s_r.cs_n;
  assign slot_as_n_o = s_r.as_n;
  assign slot_ds_n_o = s_r.ds_n;
  assign slot_wr_n_o = s_r.wr_n;
  assign slot_addr_o = s_r.maddr;
  assign slot_data_o = s_r.mdat;
  assign slot_data_oe_o = s_r.moe;

endmodule : mmc_carrier

// *** mmc_slot_model.sv ***
module mmc_slot_model (
  input wire logic core_clk_i, // Clock
  input wire logic [3:0] cs_n_i, // Selects
  input wire logic [3:0] ds_n_i, // Byte strobes
  input wire logic wr_n_i, // Write low
  input wire logic [31:0] data_i, // From carrier
  input wire logic data_oe_i, // Carrier drives data
  input wire logic [3:0] mute_i, // Never acks
  input wire logic [3:0] slow_i, // Acks late
  output logic [31:0] data_o, // To carrier
  output logic [3:0] dtack_n_o // Acknowledge
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Slot storage and acknowledge
  logic [31:0] mem [4] = '{32'ha5a50000, 32'ha5a50001, 32'ha5a50002, 32'ha5a50003};
  logic [31:0] last = 32'h00000000;
  int cnt = 0;
  int s;
  initial dtack_n_o = 4'hf;
  initial data_o = 32'hffffffff;
  always @(posedge core_clk_i) begin
    s = 0;
    for (int i = 0; i < 4; i++) begin
      if (!cs_n_i[i]) s = i;
    end
    if (cs_n_i == 4'hf || ds_n_i == 4'hf) begin
      cnt <= 0;
      dtack_n_o <= 4'hf;
      data_o <= ~last;
    end else begin
      cnt <= cnt + 1;
      if (!mute_i[s] && cnt >= (slow_i[s] ? 6 : 1)) begin
        dtack_n_o[s] <= 1'b0;
        if (!wr_n_i && dtack_n_o[s]) mem[s] <= data_oe_i ? data_i : 32'h00000000;
      end
      if (wr_n_i) begin
        data_o <= mem[s];
        last <= mem[s];
      end
    end
  end
endmodule : mmc_slot_model

// *** mmc_carrier_monitor.sv ***
module mmc_carrier_monitor (
  input wire logic core_clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic lb_load_done_i, // Image loaded
  input wire logic lb_ads_n_i, // Address strobe
  input wire logic lb_mux_i, // Muxed mode
  input wire logic [27:0] lb_addr_i, // Address
  input wire logic [3:0] lb_be_n_i, // Byte enables
  input wire logic lb_ready_n_o, // Ready
  input wire logic local_irq_input_a_o, // Module irq
  input wire logic [3:0] slot_cs_n_o, // Selects
  input wire logic slot_as_n_o, // Address phase
  input wire logic [3:0] slot_ds_n_o, // Strobes
  input wire logic [3:0] slot_dtack_n_i, // Acks
  input wire logic [3:0] slot_irq_n_i // Requests
);
  // ==========================================
  // Helpers
  logic [8:0] sel_cnt_r;
  logic [8:0] sel_cnt_nxt;
  logic take;
  logic a08;
  assign take = !lb_ads_n_i && lb_load_done_i && lb_ready_n_o && slot_cs_n_o == 4'hf && !lb_mux_i;
  assign a08 = lb_addr_i[27:12] == mmc_pkg::A08_PAGE;
  assign sel_cnt_nxt = (slot_cs_n_o == 4'hf) ? 9'h000 : sel_cnt_r + 9'h001;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sel_cnt_r <= 9'h000;
    end else begin
      sel_cnt_r <= sel_cnt_nxt;
    end
  end
  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================
  // Properties
  ready_pulse_a: assert property (!lb_ready_n_o |=> lb_ready_n_o)
    else $error("ready longer than one cycle");
  ack_ends_a: assert property ((slot_ds_n_o != 4'hf) && ((slot_cs_n_o | slot_dtack_n_i) != 4'hf)
    |-> ##[1:3] !lb_ready_n_o) else $error("ack not followed by ready");
  one_select_a: assert property ($onehot0(~slot_cs_n_o))
    else $error("several slots selected");
  addr_phase_a: assert property (!slot_as_n_o |-> slot_cs_n_o != 4'hf ##1 slot_as_n_o)
    else $error("address phase malformed");
  timeout_bound_a: assert property (sel_cnt_r <= 9'd330)
    else $error("select outlasts timeout");
  load_gate_a: assert property ((!lb_load_done_i)[*4] |-> lb_ready_n_o && slot_cs_n_o == 4'hf)
    else $error("access served before image load");
  reg_answer_a: assert property (take && a08 && lb_addr_i[8] && lb_addr_i[7:0] == 8'h00
    |-> ##1 slot_cs_n_o == 4'hf ##1 !lb_ready_n_o) else $error("register access misrouted");
  lane_error_a: assert property (take && a08 && lb_addr_i[11] && !lb_addr_i[8]
    && lb_be_n_i[1:0] != 2'h3 && lb_be_n_i[3:2] != 2'h3 && lb_be_n_i != 4'h0
    |-> ##1 slot_cs_n_o == 4'hf ##1 (!lb_ready_n_o && slot_cs_n_o == 4'hf))
    else $error("split lanes reached module");
  irq_quiet_a: assert property ((slot_irq_n_i == 4'hf)[*3] |-> !local_irq_input_a_o)
    else $error("module irq without request");
endmodule : mmc_carrier_monitor

bind mmc_carrier mmc_carrier_monitor u_mon (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .lb_load_done_i(lb_load_done_i), .lb_ads_n_i(lb_ads_n_i), .lb_mux_i(lb_mux_i),
  .lb_addr_i(lb_addr_i), .lb_be_n_i(lb_be_n_i), .lb_ready_n_o(lb_ready_n_o),
  .local_irq_input_a_o(local_irq_input_a_o), .slot_cs_n_o(slot_cs_n_o),
  .slot_as_n_o(slot_as_n_o), .slot_ds_n_o(slot_ds_n_o), .slot_dtack_n_i(slot_dtack_n_i),
  .slot_irq_n_i(slot_irq_n_i));

// *** mmc_carrier_tb.sv ***
module mmc_carrier_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Bench signals
  logic clk = 1'b0, rst_n = 1'b0, bus32 = 1'b1, mux = 1'b0, load_done = 1'b0;
  logic ads_n = 1'b1, wr = 1'b0, ready_n, oe, irq_a, irq_b, as_n, wr_n, sdo_oe;
  logic [27:0] addr = 28'h0000000;
  logic [3:0] be_n = 4'hf, slot_irq_n = 4'hf, mute = 4'h0, slow = 4'h5;
  logic [3:0] cs_n, ds_n, dtack_n;
  logic [31:0] din = 32'h00000000, dout, ee_data, sdo, sdi, q;
  logic [4:0] ee_word = 5'h00;
  logic [7:1] saddr;
  int mismatches = 0, n_tests = 0, cyc;
  localparam logic [31:0] EE_IMG [25] = '{mmc_pkg::EE_DEVICE_ID, 32'h08010001,
    mmc_pkg::EE_SUBSYS_ID, 32'h00000100, 32'h0ffff800, 32'h0ffff801, 32'h0ffff800, 0, 0,
    32'h08000001, 32'h08000001, 32'h08000801, 0, 0, 32'h00400002, 32'h00400002,
    32'h00800002, 0, 0, 0, 0, 0, 0, 0, 32'h00220000};

  mmc_carrier dut (.core_clk_i(clk), .rst_n_i(rst_n), .lb_bus32_i(bus32), .lb_mux_i(mux),
    .lb_load_done_i(load_done), .lb_ads_n_i(ads_n), .lb_addr_i(addr), .lb_wr_i(wr),
    .lb_be_n_i(be_n), .lb_data_i(din), .lb_data_o(dout), .lb_data_oe_o(oe),
    .lb_ready_n_o(ready_n), .local_irq_input_a_o(irq_a), .local_irq_input_b_o(irq_b),
    .ee_word_i(ee_word), .ee_data_o(ee_data), .slot_cs_n_o(cs_n), .slot_as_n_o(as_n),
    .slot_ds_n_o(ds_n), .slot_wr_n_o(wr_n), .slot_addr_o(saddr), .slot_data_o(sdo),
    .slot_data_oe_o(sdo_oe), .slot_data_i(sdi), .slot_dtack_n_i(dtack_n),
    .slot_irq_n_i(slot_irq_n));
  mmc_slot_model u_mod (.core_clk_i(clk), .cs_n_i(cs_n), .ds_n_i(ds_n), .wr_n_i(wr_n),
    .data_i(sdo), .data_oe_i(sdo_oe), .mute_i(mute), .slow_i(slow), .data_o(sdi),
    .dtack_n_o(dtack_n));

  // ==========================================
  // Tasks
  task automatic end_sim;
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [27:0] a, input logic [3:0] b,
    input logic [31:0] d);
    @(posedge clk);
    #1;
    ads_n = 1'b0;
    wr = w;
    be_n = b;
    addr = mux ? 28'h0000000 : a;
    din = mux ? {4'h0, a} : d;
    @(posedge clk);
    #1;
    ads_n = 1'b1;
    for (cyc = 0; cyc < 400 && ready_n !== 1'b0; cyc++) begin
      @(posedge clk);
      #1;
    end
    if (cyc == 400) begin
      mismatches++;
      end_sim();
    end
    chk("read drive", 32'(!w), oe);
    q = dout;
  endtask : acc

  initial begin
    forever #25 clk = ~clk;
  end

  // ==========================================
  // Scenarios
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    ads_n = 1'b0;
    addr = 28'h8000100;
    @(posedge clk);
    #1;
    ads_n = 1'b1;
    repeat (6) begin
      @(posedge clk);
      #1;
      chk("early ready", 1, ready_n);
    end
    load_done = 1'b1;
    for (int w = 0; w < 25; w++) begin
      ee_word = w[4:0];
      @(posedge clk);
      #1;
      chk("image word", EE_IMG[w], ee_data);
    end
    for (int s = 0; s < 4; s++) begin
      acc(0, 28'h8000100 + 28'(s * 512), 4'hc, 0);
      chk("reg d16", 0, q[3:0]);
      acc(0, 28'h8000900 + 28'(s * 512), 4'hc, 0);
      chk("reg d32", 0, q[3:0]);
      acc(0, 28'h8000004 + 28'(s * 512), 4'hc, 0);
      chk("a08 d16", 32'(s), q[15:0]);
      chk("slot address", 32'h00000002, saddr);
      acc(0, 28'h8000808 + 28'(s * 512), 4'h0, 0);
      chk("a08 d32", 32'ha5a50000 + 32'(s), q);
      acc(0, 28'h4000010 + 28'(s) * 28'h1000000, 4'h0, 0);
      chk("a24 d32", 32'ha5a50000 + 32'(s), q);
      acc(0, 28'h0000020 + 28'(s) * 28'h1000000, 4'hc, 0);
      chk("a24 d16", 32'(s), q[15:0]);
      chk("a24 address", 32'h00000010, saddr);
    end
    acc(1, 28'h8000a0c, 4'h0, 32'h12345678);
    acc(0, 28'h8000a0c, 4'h0, 0);
    chk("d32 write back", 32'h12345678, q);
    bus32 = 1'b0;
    acc(0, 28'h8000a0c, 4'h0, 0);
    chk("narrow bus", 32'h00005678, q);
    bus32 = 1'b1;
    mux = 1'b1;
    acc(0, 28'h8000404, 4'hc, 0);
    chk("muxed read", 2, q[15:0]);
    mux = 1'b0;
    acc(0, 28'h9000000, 4'h0, 0);
    chk("unmapped", 0, q);
    acc(1, 28'h8000a00, 4'ha, 32'hffffffff);
    repeat (2) @(posedge clk);
    #1;
    chk("lane irq b", 1, irq_b);
    acc(0, 28'h8000b00, 4'hc, 0);
    chk("lane flag", 4'h8, q[3:0]);
    acc(0, 28'h8000a0c, 4'h0, 0);
    chk("lane no cycle", 32'h12345678, q);
    acc(1, 28'h8000300, 4'hc, 0);
    acc(0, 28'h8000b00, 4'hc, 0);
    chk("lane clear", 0, q[3:0]);
    chk("lane irq b low", 0, irq_b);
    mute = 4'h8;
    acc(0, 28'h8000604, 4'hc, 0);
    chk("timeout length", 1, 32'(cyc >= 320));
    repeat (2) @(posedge clk);
    #1;
    chk("timeout irq b", 1, irq_b);
    acc(0, 28'h8000f00, 4'hc, 0);
    chk("timeout flag", 4'h4, q[3:0]);
    acc(1, 28'h8000700, 4'hc, 0);
    acc(0, 28'h8000700, 4'hc, 0);
    chk("timeout clear", 0, q[3:0]);
    chk("timeout irq b low", 0, irq_b);
    slot_irq_n = 4'hb;
    repeat (3) @(posedge clk);
    acc(0, 28'h8000500, 4'hc, 0);
    chk("pending", 4'h1, q[3:0]);
    chk("gated irq a", 0, irq_a);
    acc(1, 28'h8000d00, 4'hc, 32'h00000002);
    repeat (2) @(posedge clk);
    #1;
    chk("irq a", 1, irq_a);
    acc(0, 28'h8000300, 4'hc, 0);
    chk("other slot", 0, q[3:0]);
    slot_irq_n = 4'hf;
    repeat (3) @(posedge clk);
    #1;
    chk("irq a low", 0, irq_a);
    acc(0, 28'h8000500, 4'hc, 0);
    chk("gate kept", 4'h2, q[3:0]);
    end_sim();
  end
endmodule : mmc_carrier_tb
